// ==== iocr_pkg.sv ====
package iocr_pkg;

    localparam logic [5:0] IOCR_ADDR_FIRST = 6'h00;
    localparam logic [5:0] IOCR_ADDR_SECOND = 6'h01;

    // First register fields
    localparam int IOCR_F1_SINGLE_POS = 7;
    localparam int IOCR_F1_ALT_DRV_POS = 6;
    localparam int IOCR_F1_RX_WL_POS = 5;
    localparam int IOCR_F1_TX_WL_POS = 4;
    localparam int IOCR_F1_XTAL_POS = 3;
    localparam int IOCR_F1_DIV_HI_POS = 2;
    localparam int IOCR_F1_DIV_LO_POS = 1;
    localparam int IOCR_F1_LF_OFF_POS = 0;
    localparam logic [7:0] IOCR_F1_RESET = 8'h08;
    localparam logic [7:0] IOCR_F1_MASK = 8'hff;

    // Second register fields
    localparam int IOCR_F2_SUPPLY_POS = 7;
    localparam int IOCR_F2_VREG_OFF_POS = 6;
    localparam int IOCR_F2_PD_SEL_POS = 4;
    localparam int IOCR_F2_PD_IDLE_POS = 3;
    localparam int IOCR_F2_DRIVE_POS = 2;
    localparam int IOCR_F2_SLOW_POS = 0;
    localparam logic [7:0] IOCR_F2_RESET = 8'h00;
    localparam logic [7:0] IOCR_F2_MASK = 8'hdd;

    // Water levels in bytes
    localparam logic [6:0] IOCR_RX_WL_LOW = 7'h40;
    localparam logic [6:0] IOCR_RX_WL_HIGH = 7'h50;
    localparam logic [6:0] IOCR_TX_WL_LOW = 7'h20;
    localparam logic [6:0] IOCR_TX_WL_HIGH = 7'h10;

    // Clock output selection codes
    localparam logic [1:0] IOCR_CLK_DIV4 = 2'h0;
    localparam logic [1:0] IOCR_CLK_DIV2 = 2'h1;
    localparam logic [1:0] IOCR_CLK_DIV1 = 2'h2;
    localparam logic [1:0] IOCR_CLK_OFF = 2'h3;

    // Slow transmitter ramp, least rise time
    localparam int IOCR_CLK_MHZ = 50;
    localparam int IOCR_SLOW_RAMP_US = 10;
    localparam int IOCR_SLOW_RAMP_CYC = IOCR_SLOW_RAMP_US * IOCR_CLK_MHZ;

    typedef struct packed {
        logic single_ended;
        logic alt_driver_select;
        logic rx_water_level_sel;
        logic tx_water_level_sel;
        logic xtal_27m;
        logic clkout_div_hi;
        logic clkout_div_lo;
        logic lowfreq_clkout_disable;
    } iocr_first_type;

    typedef struct packed {
        logic supply_range_sel;
        logic vreg_off;
        logic unused5;
        logic sdo_pulldown_selected;
        logic sdo_pulldown_idle;
        logic sdo_strong_drive;
        logic unused1;
        logic tx_slow_ramp;
    } iocr_second_type;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } iocr_bus_type;

endpackage

// ==== iocr_top.sv ====
// Operation
// RL1 - Both registers take their defaults only at power-up, nothing else restores them.
// RL2 - First register bit 7 set picks one antenna driver, clear picks differential drive.
// RL3 - First register bit 6 picks the first or second driver and receive input pair.
// RL4 - First register bit 5 sets the receive water level to 64 or 80 bytes.
// RL5 - First register bit 4 sets the transmit water level to 32 or 16 bytes.
// RL6 - First register bit 3, default 1, selects a 13.56 or 27.12 MHz crystal.
// RL7 - With the crystal running, bits 2:1 give 3.39, 6.78 or 13.56 MHz on the clock output.
// RL8 - Code 11 in bits 2:1 holds the clock output low.
// RL9 - With the crystal stopped and output enabled, the 32 kHz clock shows unless bit 0 is set.
// RL10 - Second register bit 7 selects the 5 V range when clear and 3.3 V when set.
// RL11 - Second register bit 6 set turns the digital supply regulator off.
// RL12 - Second register bit 4 pulls the serial output down while selected and not driven.
// RL13 - Second register bit 3 pulls the serial output down while not selected.
// RL14 - Second register bit 2 raises the serial output drive strength.
// RL15 - Second register bit 0 makes the transmitter ramp up over at least 10 us.
// RL16 - Unused bits read as zero and ignore writes.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module iocr_top
    import iocr_pkg::*;
(
    input wire logic clk_i,                     // 50 MHz system clock
    input wire logic reset_n_i,                 // Power-up reset, async, active low
    input wire logic [5:0] addr_i,              // Register address
    input wire logic [7:0] wdata_i,             // Write data
    input wire logic wr_i,                      // Write strobe
    input wire logic rd_i,                      // Read strobe
    output logic [7:0] rdata_o,                 // Read data, cycle after rd_i
    input wire logic xtal_running_i,            // Crystal oscillator running (pin domain)
    input wire logic xtal_clk_i,                // Crystal-derived clock at the fastest output rate, as a level
    input wire logic lf_clk_i,                  // 32 kHz low-frequency clock level
    input wire logic sel_n_i,                   // Serial select pin, active low
    input wire logic sdo_oe_i,                  // Serial output driven by the device
    input wire logic tx_on_i,                   // Transmitter turned on
    output logic single_ended_o,                // One antenna driver
    output logic alt_driver_select_o,           // Second driver pair
    output logic [6:0] rx_water_level_o,        // Receive water level in bytes
    output logic [6:0] tx_water_level_o,        // Transmit water level in bytes
    output logic xtal_27m_o,                    // 27.12 MHz crystal selected
    output logic [1:0] clkout_sel_o,            // Divider select for clock output
    output logic clkout_o,                      // Microcontroller clock output
    output logic supply_range_sel_o,            // 3.3 V range
    output logic vreg_off_o,                    // Digital regulator off
    output logic sdo_pulldown_o,                // Serial output pull-down active
    output logic sdo_strong_drive_o,            // Raised serial output drive
    output logic tx_ramp_active_o               // Slow ramp in progress
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    iocr_bus_type bus;
    iocr_first_type first_q;
    iocr_second_type second_q;
    logic [7:0] rdata_q;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    function automatic logic [7:0] read_mux(input logic [5:0] a, input logic [7:0] r1,
                                            input logic [7:0] r2);
        if (a == IOCR_ADDR_FIRST) begin
            return r1;
        end else if (a == IOCR_ADDR_SECOND) begin
            return r2 & IOCR_F2_MASK; // RL16
        end
        return 8'h00;
    endfunction

    // Only the power-up reset loads defaults
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            first_q <= IOCR_F1_RESET; // RL1
        end else if (bus.wr && bus.addr == IOCR_ADDR_FIRST) begin
            first_q <= bus.wdata & IOCR_F1_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            second_q <= IOCR_F2_RESET; // RL1
        end else if (bus.wr && bus.addr == IOCR_ADDR_SECOND) begin
            second_q <= bus.wdata & IOCR_F2_MASK; // RL16
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            rdata_q <= read_mux(bus.addr, first_q, second_q);
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, change taken when stages two and three agree

    localparam int NSYNC = 6;
    // Stages reset to the pins' idle levels, so no false select edge follows reset
    localparam logic [NSYNC-1:0] PIN_IDLE = {{(NSYNC-3){1'b0}}, 1'b1, 2'b00};
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, pin_q;

    assign pin_raw = {xtal_running_i, xtal_clk_i, lf_clk_i, sel_n_i, sdo_oe_i, tx_on_i};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_q <= PIN_IDLE;
            s2_q <= PIN_IDLE;
            s3_q <= PIN_IDLE;
            pin_q <= PIN_IDLE;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    pin_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic xtal_run, xtal_clk, lf_clk, sel_n, sdo_oe, tx_on;
    assign {xtal_run, xtal_clk, lf_clk, sel_n, sdo_oe, tx_on} = pin_q;

    ////////////////////////////////////////////////////////////////////////////
    // Clock output divider from the crystal-derived level

    logic xclk_d1_q;
    logic [1:0] div_q;
    logic clkout_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xclk_d1_q <= 1'b0;
            div_q <= 2'h0;
        end else begin
            xclk_d1_q <= xtal_clk;
            if (xtal_clk && !xclk_d1_q) begin
                div_q <= div_q + 2'h1;
            end
        end
    end

    // Input level is already the fastest rate; divider halves it per step
    function automatic logic pick_clk(input logic [1:0] sel, input logic x,
                                      input logic [1:0] d);
        unique case (sel)
            IOCR_CLK_DIV1: return x;
            IOCR_CLK_DIV2: return d[0];
            IOCR_CLK_DIV4: return d[1];
            IOCR_CLK_OFF:  return 1'b0;
        endcase
        return 1'b0;
    endfunction

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clkout_q <= 1'b0;
        end else if ({first_q.clkout_div_hi, first_q.clkout_div_lo} == IOCR_CLK_OFF) begin
            clkout_q <= 1'b0; // RL8
        end else if (xtal_run) begin
            clkout_q <= pick_clk({first_q.clkout_div_hi, first_q.clkout_div_lo},
                                 xtal_clk, div_q); // RL7
        end else begin
            clkout_q <= lf_clk & ~first_q.lowfreq_clkout_disable; // RL9
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial output pad control and transmitter ramp

    logic pd_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= (sel_n && second_q.sdo_pulldown_idle) // RL13
                 || (!sel_n && !sdo_oe && second_q.sdo_pulldown_selected); // RL12
        end
    end

    // Counter runs the whole least rise time; a turn-off aborts it
    logic [$clog2(IOCR_SLOW_RAMP_CYC+1)-1:0] ramp_cnt_q;
    logic tx_on_d1_q;
    logic ramp_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_on_d1_q <= 1'b0;
            ramp_cnt_q <= '0;
            ramp_q <= 1'b0;
        end else begin
            tx_on_d1_q <= tx_on;
            if (!tx_on) begin
                ramp_cnt_q <= '0;
                ramp_q <= 1'b0;
            end else if (!tx_on_d1_q && second_q.tx_slow_ramp) begin
                ramp_cnt_q <= ($bits(ramp_cnt_q))'(IOCR_SLOW_RAMP_CYC - 1); // RL15
                ramp_q <= 1'b1;
            end else if (ramp_cnt_q != '0) begin
                ramp_cnt_q <= ramp_cnt_q - 1'b1;
            end else begin
                ramp_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered configuration outputs

    logic [6:0] rx_wl_q, tx_wl_q;
    logic [1:0] csel_q;
    logic single_q, alt_q, x27_q, sup_q, vreg_q, drive_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            single_q <= 1'b0;
            alt_q <= 1'b0;
            rx_wl_q <= IOCR_RX_WL_LOW;
            tx_wl_q <= IOCR_TX_WL_LOW;
            x27_q <= IOCR_F1_RESET[IOCR_F1_XTAL_POS];
            csel_q <= IOCR_CLK_DIV4;
            sup_q <= 1'b0;
            vreg_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            single_q <= first_q.single_ended; // RL2
            alt_q <= first_q.alt_driver_select; // RL3
            rx_wl_q <= first_q.rx_water_level_sel ? IOCR_RX_WL_HIGH : IOCR_RX_WL_LOW; // RL4
            tx_wl_q <= first_q.tx_water_level_sel ? IOCR_TX_WL_HIGH : IOCR_TX_WL_LOW; // RL5
            x27_q <= first_q.xtal_27m; // RL6
            csel_q <= {first_q.clkout_div_hi, first_q.clkout_div_lo}; // RL7
            sup_q <= second_q.supply_range_sel; // RL10
            vreg_q <= second_q.vreg_off; // RL11
            drive_q <= second_q.sdo_strong_drive; // RL14
        end
    end

    assign single_ended_o = single_q;
    assign alt_driver_select_o = alt_q;
    assign rx_water_level_o = rx_wl_q;
    assign tx_water_level_o = tx_wl_q;
    assign xtal_27m_o = x27_q;
    assign clkout_sel_o = csel_q;
    assign clkout_o = clkout_q;
    assign supply_range_sel_o = sup_q;
    assign vreg_off_o = vreg_q;
    assign sdo_pulldown_o = pd_q;
    assign sdo_strong_drive_o = drive_q;
    assign tx_ramp_active_o = ramp_q;

endmodule
`default_nettype wire

// ==== iocr_top_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module iocr_top_monitor
    import iocr_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic single_ended_o,
    input wire logic alt_driver_select_o,
    input wire logic [6:0] rx_water_level_o,
    input wire logic [6:0] tx_water_level_o,
    input wire logic xtal_27m_o,
    input wire logic [1:0] clkout_sel_o,
    input wire logic clkout_o,
    input wire logic supply_range_sel_o,
    input wire logic vreg_off_o,
    input wire logic sdo_strong_drive_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////////
    // Config outputs settle two edges after the write strobe
    sequence s_wr_first;
        wr_i && addr_i == IOCR_ADDR_FIRST ##2 1'b1;
    endsequence
    sequence s_wr_second;
        wr_i && addr_i == IOCR_ADDR_SECOND ##2 1'b1;
    endsequence
    property p_wr_first;
        s_wr_first |-> {single_ended_o, alt_driver_select_o, xtal_27m_o, clkout_sel_o}
            == {$past(wdata_i[7:6], 2), $past(wdata_i[3:1], 2)};
    endproperty
    a_wr_first: assert property (p_wr_first) else $error("first reg outputs wrong");
    property p_wr_second;
        s_wr_second |-> {supply_range_sel_o, vreg_off_o, sdo_strong_drive_o}
            == {$past(wdata_i[7:6], 2), $past(wdata_i[2], 2)};
    endproperty
    a_wr_second: assert property (p_wr_second) else $error("second reg outputs wrong");
    property p_rd_first;
        rd_i && addr_i == IOCR_ADDR_FIRST |=> rdata_o[7:1] == {single_ended_o,
            alt_driver_select_o, rx_water_level_o == IOCR_RX_WL_HIGH,
            tx_water_level_o == IOCR_TX_WL_HIGH, xtal_27m_o, clkout_sel_o};
    endproperty
    a_rd_first: assert property (p_rd_first) else $error("first reg read wrong");
    property p_rd_second;
        rd_i && addr_i == IOCR_ADDR_SECOND |=> {rdata_o[7:5], rdata_o[2:1]}
            == {supply_range_sel_o, vreg_off_o, 1'b0, sdo_strong_drive_o, 1'b0};
    endproperty
    a_rd_second: assert property (p_rd_second) else $error("second reg read wrong");
    property p_rd_unmapped;
        rd_i && addr_i > IOCR_ADDR_SECOND |=> rdata_o == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rd_quiet;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside answer");
    property p_clk_off;
        clkout_sel_o == IOCR_CLK_OFF [*4] |-> !clkout_o;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock output not low");
    property p_wl_legal;
        (rx_water_level_o == IOCR_RX_WL_LOW || rx_water_level_o == IOCR_RX_WL_HIGH)
            && (tx_water_level_o == IOCR_TX_WL_LOW || tx_water_level_o == IOCR_TX_WL_HIGH);
    endproperty
    a_wl_legal: assert property (p_wl_legal) else $error("water level illegal");
endmodule
`default_nettype wire

// ==== tb_iocr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_iocr_top;
    import iocr_pkg::*;
    logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, xrun = 0, xclk = 0, lfc = 0;
    logic sel_n = 1, oe = 0, txon = 0, se, alt, x27, cko, sup, vro, pd, drv, ramp;
    logic [5:0] addr_i = 6'h00;
    logic [7:0] wdata_i = 8'h00, rdata_o, d;
    logic [6:0] rxw, txw;
    logic [1:0] csel;
    int mismatches = 0, total_checks = 0, cyc = 0;
    initial forever #10 clk_i = ~clk_i;
    // Slow stand-ins for the crystal and 32 kHz clocks, kept below clk_i/4
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        xclk <= cyc[3];
        lfc <= cyc[5];
    end
    iocr_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .xtal_running_i(xrun), .xtal_clk_i(xclk),
        .lf_clk_i(lfc), .sel_n_i(sel_n), .sdo_oe_i(oe), .tx_on_i(txon), .single_ended_o(se),
        .alt_driver_select_o(alt), .rx_water_level_o(rxw), .tx_water_level_o(txw),
        .xtal_27m_o(x27), .clkout_sel_o(csel), .clkout_o(cko), .supply_range_sel_o(sup),
        .vreg_off_o(vro), .sdo_pulldown_o(pd), .sdo_strong_drive_o(drv),
        .tx_ramp_active_o(ramp));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge clk_i);
        rd_i <= 1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 0;
        #1 d = rdata_o;
    endtask
    task automatic edges(input int e);
        int n;
        logic p;
        n = 0;
        repeat (16) @(posedge clk_i);
        p = cko;
        repeat (512) begin
            @(posedge clk_i);
            #1;
            if (cko === 1'b1 && p === 1'b0) n++;
            p = cko;
        end
        chk({7'h00, n + 1 >= e && n <= e + 1}, 8'h01);
    endtask
    task automatic pins(input logic s, input logic o, input logic e);
        @(posedge clk_i);
        sel_n <= s;
        oe <= o;
        repeat (10) @(posedge clk_i);
        #1 chk({7'h00, pd}, {7'h00, e});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        rd(IOCR_ADDR_FIRST);
        chk(d, 8'h08);
        rd(IOCR_ADDR_SECOND);
        chk(d, 8'h00);
        chk({1'b0, rxw}, {1'b0, IOCR_RX_WL_LOW});
        chk({1'b0, txw}, {1'b0, IOCR_TX_WL_LOW});
        chk({7'h00, x27}, 8'h01);
        chk({se, alt, csel, sup, vro, drv, pd}, 8'h00);
    endtask
    task automatic t_first();
        logic [7:0] vals [4] = '{8'hff, 8'h00, 8'h31, 8'hc6};
        foreach (vals[i]) begin
            wr(IOCR_ADDR_FIRST, vals[i]);
            rd(IOCR_ADDR_FIRST);
            chk(d, vals[i]);
            chk({se, alt, 2'b00, x27, csel, 1'b0}, vals[i] & 8'hce);
            chk({1'b0, rxw}, vals[i][5] ? 8'h50 : 8'h40);
            chk({1'b0, txw}, vals[i][4] ? 8'h10 : 8'h20);
        end
    endtask
    task automatic t_second();
        wr(IOCR_ADDR_SECOND, 8'hff);
        rd(IOCR_ADDR_SECOND);
        chk(d, 8'hdd);
        chk({5'h00, sup, vro, drv}, 8'h07);
        wr(6'h02, 8'hff);
        rd(6'h02);
        chk(d, 8'h00);
        rd(IOCR_ADDR_FIRST);
        chk(d, 8'hc6);
        wr(IOCR_ADDR_SECOND, 8'h00);
    endtask
    task automatic t_clk();
        @(posedge clk_i);
        xrun <= 1;
        for (int s = 0; s < 4; s++) begin
            wr(IOCR_ADDR_FIRST, {5'h01, s[1:0], 1'b0});
            edges(s == 3 ? 0 : 8 << s);
        end
        @(posedge clk_i);
        xrun <= 0;
        wr(IOCR_ADDR_FIRST, 8'h08);
        edges(8);
        wr(IOCR_ADDR_FIRST, 8'h09);
        edges(0);
    endtask
    task automatic t_pull();
        wr(IOCR_ADDR_SECOND, 8'h08);
        pins(1, 0, 1);
        pins(0, 0, 0);
        wr(IOCR_ADDR_SECOND, 8'h10);
        pins(0, 0, 1);
        pins(0, 1, 0);
        pins(1, 0, 0);
    endtask
    task automatic t_ramp();
        // Ramp lasts 500 cycles after the synchroniser, so sample well inside and past it
        wr(IOCR_ADDR_SECOND, 8'h01);
        @(posedge clk_i);
        txon <= 1;
        repeat (20) @(posedge clk_i);
        #1 chk({7'h00, ramp}, 8'h01);
        repeat (460) @(posedge clk_i);
        #1 chk({7'h00, ramp}, 8'h01);
        repeat (50) @(posedge clk_i);
        #1 chk({7'h00, ramp}, 8'h00);
        txon <= 0;
        wr(IOCR_ADDR_SECOND, 8'h00);
        @(posedge clk_i);
        txon <= 1;
        repeat (20) @(posedge clk_i);
        #1 chk({7'h00, ramp}, 8'h00);
        txon <= 0;
    endtask
    task automatic t_reset();
        // Non-default contents, so the restore of both registers is visible
        wr(IOCR_ADDR_SECOND, 8'hdd);
        @(posedge clk_i);
        reset_n_i <= 0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1;
        t_defaults();
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1;
        t_defaults();
        t_first();
        t_second();
        t_clk();
        t_pull();
        t_ramp();
        t_reset();
        summarize();
    end
    // Whole run is about 3850 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        summarize();
    end
endmodule
bind iocr_top iocr_top_monitor u_mon (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .single_ended_o(single_ended_o), .alt_driver_select_o(alt_driver_select_o),
    .rx_water_level_o(rx_water_level_o), .tx_water_level_o(tx_water_level_o),
    .xtal_27m_o(xtal_27m_o), .clkout_sel_o(clkout_sel_o), .clkout_o(clkout_o),
    .supply_range_sel_o(supply_range_sel_o), .vreg_off_o(vreg_off_o),
    .sdo_strong_drive_o(sdo_strong_drive_o));
`default_nettype wire
